// ---- verilog/dip_crest_pkg.sv ----
`default_nettype none
package dip_crest_pkg;

    // Register word addresses on the register port
    localparam logic [7:0] EVENT_STATUS_ADDR     = 8'h00;
    localparam logic [7:0] EVENT_ENABLE_ADDR     = 8'h04;
    localparam logic [7:0] PHASE_STATUS_ADDR     = 8'h08;
    localparam logic [7:0] DIP_THRESHOLD_ADDR    = 8'h0c;
    localparam logic [7:0] DIP_CYCLES_ADDR       = 8'h10;
    localparam logic [7:0] CREST_CYCLES_ADDR     = 8'h14;
    localparam logic [7:0] MEAS_MODE_ADDR        = 8'h18;
    localparam logic [7:0] CURRENT_CREST_ADDR    = 8'h1c;
    localparam logic [7:0] VOLTAGE_CREST_ADDR    = 8'h20;

    // Field positions
    localparam int DIP_BIT           = 16;
    localparam int CURRENT_DONE_BIT  = 23;
    localparam int VOLTAGE_DONE_BIT  = 24;
    localparam int DIP_PHASE_LSB     = 12;
    localparam int CREST_SEL_LSB     = 2;
    localparam int CREST_PHASE_LSB   = 24;
    localparam int SAMPLE_WIDTH      = 24;
    localparam int PHASES            = 3;

    // Reset values
    localparam logic [31:0] EVENT_ENABLE_RESET  = 32'h0000_0000;
    localparam logic [23:0] DIP_THRESHOLD_RESET = 24'h00_0000;
    localparam logic [7:0]  DIP_CYCLES_RESET    = 8'h01;
    localparam logic [7:0]  CREST_CYCLES_RESET  = 8'h00;
    localparam logic [2:0]  CREST_SEL_RESET     = 3'h0;

    // Thresholds of one count or less switch dip detection off
    localparam logic [23:0] DIP_THRESHOLD_OFF   = 24'h00_0001;
    // Largest magnitude of the high-pass output
    localparam logic [23:0] FULL_SCALE          = 24'h5a_7540;

    // Magnitude of a signed sample; the most negative code saturates
    function automatic logic [23:0] magnitude_of(input logic [23:0] sample);
        logic [23:0] neg;
        neg = 24'h00_0000 - sample;
        if (!sample[23])
            return sample;
        else if (neg[23])
            return 24'h7f_ffff;
        else
            return neg;
    endfunction : magnitude_of

endpackage : dip_crest_pkg
`default_nettype wire

// ---- verilog/dip_phase_timer.sv ----
`default_nettype none
module dip_phase_timer
    import dip_crest_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        sample_valid,
    input  wire logic [23:0] magnitude,
    input  wire logic [23:0] dip_threshold,
    input  wire logic [7:0]  dip_half_cycles,
    input  wire logic        zero_cross,
    input  wire logic        restart,
    output logic             dip_event
);

    logic       below_all;
    logic [7:0] half_count;
    logic       detect_on;

    // Thresholds of 0 or 1 never trigger
    assign detect_on = (dip_threshold > DIP_THRESHOLD_OFF);

    // Half cycle counts only if every sample in it stayed at or under the threshold
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            below_all <= 1'b0;
        else if (restart || !detect_on)
            below_all <= 1'b0;
        else if (zero_cross)
            below_all <= 1'b1;
        else if (sample_valid && magnitude > dip_threshold)
            below_all <= 1'b0;
    end

    // Consecutive half cycles under threshold; fires at end of the Nth
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            half_count <= 8'h00;
            dip_event  <= 1'b0;
        end
        else
        begin
            dip_event <= 1'b0;
            // A threshold switched off must not let a pending count fire
            if (restart || !detect_on)
                half_count <= 8'h00;
            else if (zero_cross)
            begin
                if (!below_all)
                    half_count <= 8'h00;
                else if (half_count + 8'h01 >= dip_half_cycles && dip_half_cycles != 8'h00)
                begin
                    half_count <= 8'h00;
                    dip_event  <= 1'b1;
                end
                else
                    half_count <= half_count + 8'h01;
            end
        end
    end

    AST_DIP_RESTART_CLEARS: assert property (@(posedge sys_clk) disable iff (!resetn)
        restart |=> (half_count == 8'h00) && !dip_event)
        else $error("dip counter not cleared by restart");

    AST_DIP_OFF_SILENT: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!detect_on)[*2] |-> !dip_event)
        else $error("dip fired with threshold switched off");

endmodule : dip_phase_timer
`default_nettype wire

// ---- verilog/dip_crest_monitor.sv ----
`default_nettype none
// Functional notes
// - Flag a phase whose voltage magnitude stays at or under threshold for N half cycles.
// - A dip sets event status bit 16 and that phase's flag together.
// - Writing one to status bit 16 clears it, all phase flags, releases interrupt.
// - Dip fires at end of Nth half cycle under threshold; zero is invalid.
// - With enable bit 16 set, interrupt falls in the cycle status bit sets.
// - A later dip on another phase replaces the earlier phase flag.
// - Writing dip cycle count with threshold set restarts the half-cycle counter.
// - Threshold compared with filtered magnitude; 0 or 1 never triggers.
// - Threshold reads and writes as 32-bit word, top eight bits zero.
// - Track largest voltage and current magnitudes per window in low 24 bits.
// - Select bits 2..4 pick phases; every selected zero crossing counts.
// - Each stored crest sets one phase bit of 26..24, clearing the old one.
// - Crest value and phase stored at window end, held through next window.
// - Window end sets status bit 23 for current, bit 24 for voltage.
// - Enabled crest status bits pull the interrupt low at window end.
// - Writing crest cycle count with phases selected restarts the window counter.
module dip_crest_monitor
    import dip_crest_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               resetn,
    // Register port behind the serial interface
    input  wire logic               reg_write,
    input  wire logic               reg_read,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    output logic      [31:0]        reg_rdata,
    output logic                    reg_rvalid,
    // Filtered samples and zero-crossing events, same clock
    input  wire logic               sample_valid,
    input  wire logic [2:0][23:0]   volt_sample,
    input  wire logic [2:0][23:0]   curr_sample,
    input  wire logic [2:0]         zero_cross,
    // Interrupt pin
    output logic                    event_irq_n
);

    logic [31:0]      event_status_reg;
    logic [31:0]      next_status;
    logic [31:0]      event_enable_reg;
    logic [2:0]       dip_phase_flags;
    logic [23:0]      dip_threshold;
    logic [7:0]       dip_half_cycles;
    logic [7:0]       crest_half_cycles;
    logic [2:0]       crest_phase_select;
    logic [31:0]      current_crest_record;
    logic [31:0]      voltage_crest_record;
    logic [2:0]       dip_event;
    logic             dip_restart;
    logic             crest_restart;
    logic [7:0]       window_count;
    logic [7:0]       next_window_count;
    logic             window_end;
    logic [23:0]      volt_max;
    logic [2:0]       volt_max_phase;
    logic [23:0]      curr_max;
    logic [2:0]       curr_max_phase;
    logic [23:0]      next_volt_max;
    logic [2:0]       next_volt_phase;
    logic [23:0]      next_curr_max;
    logic [2:0]       next_curr_phase;
    logic [2:0][23:0] volt_mag;
    logic [2:0][23:0] curr_mag;
    logic             status_write;
    logic [2:0]       zero_cross_sel;

    assign status_write = reg_write && (reg_addr == EVENT_STATUS_ADDR);
    // Restart only when the matching function is armed
    assign dip_restart   = reg_write && (reg_addr == DIP_CYCLES_ADDR) && (dip_threshold != 24'h00_0000);
    assign crest_restart = reg_write && (reg_addr == CREST_CYCLES_ADDR) && (crest_phase_select != 3'h0);
    assign zero_cross_sel = zero_cross & crest_phase_select;

    // One dip timer per phase
    genvar ph;
    generate
        for (ph = 0; ph < PHASES; ph++)
        begin : g_phase
            assign volt_mag[ph] = magnitude_of(volt_sample[ph]);
            assign curr_mag[ph] = magnitude_of(curr_sample[ph]);

            dip_phase_timer u_dip_timer (
                .sys_clk         (sys_clk),
                .resetn          (resetn),
                .sample_valid    (sample_valid),
                .magnitude       (volt_mag[ph]),
                .dip_threshold   (dip_threshold),
                .dip_half_cycles (dip_half_cycles),
                .zero_cross      (zero_cross[ph]),
                .restart         (dip_restart),
                .dip_event       (dip_event[ph])
            );
        end
    endgenerate

    // Configuration registers written by the host
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            event_enable_reg   <= EVENT_ENABLE_RESET;
            dip_threshold      <= DIP_THRESHOLD_RESET;
            dip_half_cycles    <= DIP_CYCLES_RESET;
            crest_half_cycles  <= CREST_CYCLES_RESET;
            crest_phase_select <= CREST_SEL_RESET;
        end
        else if (reg_write)
        begin
            case (reg_addr)
                EVENT_ENABLE_ADDR:  event_enable_reg   <= reg_wdata;
                DIP_THRESHOLD_ADDR: dip_threshold      <= reg_wdata[23:0];
                DIP_CYCLES_ADDR:    dip_half_cycles    <= reg_wdata[7:0];
                CREST_CYCLES_ADDR:  crest_half_cycles  <= reg_wdata[7:0];
                MEAS_MODE_ADDR:     crest_phase_select <= reg_wdata[CREST_SEL_LSB +: 3];
                default:            ;
            endcase
        end
    end

    // Status: hardware set wins over a write-one clear in the same cycle
    always_comb
    begin
        next_status = event_status_reg;
        if (status_write)
            next_status = next_status & ~reg_wdata;
        if (|dip_event)
            next_status[DIP_BIT] = 1'b1;
        if (window_end)
        begin
            next_status[CURRENT_DONE_BIT] = 1'b1;
            next_status[VOLTAGE_DONE_BIT] = 1'b1;
        end
        next_status = next_status & ((32'h1 << DIP_BIT) | (32'h1 << CURRENT_DONE_BIT) | (32'h1 << VOLTAGE_DONE_BIT));
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            event_status_reg <= 32'h0000_0000;
        else
            event_status_reg <= next_status;
    end

    // Interrupt registered from next status so it falls with the status bit
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            event_irq_n <= 1'b1;
        else
            event_irq_n <= ~|(next_status & event_enable_reg);
    end

    // Phase flags show only the latest dip; cleared with the status bit
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            dip_phase_flags <= 3'h0;
        else if (|dip_event)
            dip_phase_flags <= dip_event;
        else if (status_write && reg_wdata[DIP_BIT])
            dip_phase_flags <= 3'h0;
    end

    // Crest window counter over zero crossings of all selected phases
    always_comb
    begin
        next_window_count = window_count;
        for (int i = 0; i < PHASES; i++)
        begin
            if (zero_cross_sel[i])
                next_window_count = next_window_count + 8'h01;
        end
        window_end = (crest_half_cycles != 8'h00) && (|zero_cross_sel)
                     && (next_window_count >= crest_half_cycles);
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            window_count <= 8'h00;
        else if (crest_restart)
            window_count <= 8'h00;
        else if (window_end)
            window_count <= 8'h00;
        else
            window_count <= next_window_count;
    end

    // Largest magnitude among selected phases including this sample
    always_comb
    begin
        next_volt_max   = volt_max;
        next_volt_phase = volt_max_phase;
        next_curr_max   = curr_max;
        next_curr_phase = curr_max_phase;
        if (sample_valid)
        begin
            for (int i = 0; i < PHASES; i++)
            begin
                if (crest_phase_select[i] && volt_mag[i] > next_volt_max)
                begin
                    next_volt_max   = volt_mag[i];
                    next_volt_phase = 3'h1 << i;
                end
                if (crest_phase_select[i] && curr_mag[i] > next_curr_max)
                begin
                    next_curr_max   = curr_mag[i];
                    next_curr_phase = 3'h1 << i;
                end
            end
        end
    end

    // Running maxima restart with each window and on a count rewrite
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            volt_max       <= 24'h00_0000;
            volt_max_phase <= 3'h0;
            curr_max       <= 24'h00_0000;
            curr_max_phase <= 3'h0;
        end
        else if (window_end || crest_restart)
        begin
            volt_max       <= 24'h00_0000;
            volt_max_phase <= 3'h0;
            curr_max       <= 24'h00_0000;
            curr_max_phase <= 3'h0;
        end
        else
        begin
            volt_max       <= next_volt_max;
            volt_max_phase <= next_volt_phase;
            curr_max       <= next_curr_max;
            curr_max_phase <= next_curr_phase;
        end
    end

    // Records only change at window end, so reads mid-window are stable
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            current_crest_record <= 32'h0000_0000;
            voltage_crest_record <= 32'h0000_0000;
        end
        else if (window_end)
        begin
            current_crest_record <= {5'h00, next_curr_phase, next_curr_max};
            voltage_crest_record <= {5'h00, next_volt_phase, next_volt_max};
        end
    end

    // Read data registered; unmapped addresses read zero
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata  <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_read;
            if (reg_read)
            begin
                case (reg_addr)
                    EVENT_STATUS_ADDR:  reg_rdata <= event_status_reg;
                    EVENT_ENABLE_ADDR:  reg_rdata <= event_enable_reg;
                    PHASE_STATUS_ADDR:  reg_rdata <= {17'h0_0000, dip_phase_flags, 12'h000};
                    DIP_THRESHOLD_ADDR: reg_rdata <= {8'h00, dip_threshold};
                    DIP_CYCLES_ADDR:    reg_rdata <= {24'h00_0000, dip_half_cycles};
                    CREST_CYCLES_ADDR:  reg_rdata <= {24'h00_0000, crest_half_cycles};
                    MEAS_MODE_ADDR:     reg_rdata <= {27'h000_0000, crest_phase_select, 2'h0};
                    CURRENT_CREST_ADDR: reg_rdata <= current_crest_record;
                    VOLTAGE_CREST_ADDR: reg_rdata <= voltage_crest_record;
                    default:            reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    AST_DIP_SETS_STATUS: assert property (@(posedge sys_clk) disable iff (!resetn)
        (|dip_event) |=> event_status_reg[DIP_BIT] && (dip_phase_flags == $past(dip_event)))
        else $error("dip did not set status and phase flag");

    AST_DIP_LATEST_PHASE: assert property (@(posedge sys_clk) disable iff (!resetn)
        (dip_phase_flags == 3'b001 && dip_event == 3'b010) |=> dip_phase_flags == 3'b010)
        else $error("older dip phase flag not replaced");

    AST_DIP_CLEAR: assert property (@(posedge sys_clk) disable iff (!resetn)
        (status_write && reg_wdata[DIP_BIT] && !(|dip_event))
        |=> !event_status_reg[DIP_BIT] && dip_phase_flags == 3'h0)
        else $error("dip write-one clear failed");

    AST_DIP_IRQ: assert property (@(posedge sys_clk) disable iff (!resetn)
        ($rose(event_status_reg[DIP_BIT]) && $past(event_enable_reg[DIP_BIT])) |-> !event_irq_n)
        else $error("interrupt not low with dip status");

    AST_IRQ_MATCHES: assert property (@(posedge sys_clk) disable iff (!resetn)
        event_irq_n == !(|(event_status_reg & $past(event_enable_reg) & event_enable_reg))
        || $changed(event_enable_reg))
        else $error("interrupt pin disagrees with enabled status");

    AST_CREST_STATUS: assert property (@(posedge sys_clk) disable iff (!resetn)
        window_end |=> event_status_reg[CURRENT_DONE_BIT] && event_status_reg[VOLTAGE_DONE_BIT])
        else $error("window end did not set crest status");

    AST_CREST_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
        !window_end |=> $stable(current_crest_record) && $stable(voltage_crest_record))
        else $error("crest record changed inside a window");

    AST_CREST_ONEHOT: assert property (@(posedge sys_clk) disable iff (!resetn)
        $past(window_end) && crest_phase_select != 3'h0 && $past(sample_valid)
        |-> $countones(voltage_crest_record[CREST_PHASE_LSB +: 3]) <= 1)
        else $error("crest phase bits not one-hot");

    AST_CREST_RESTART: assert property (@(posedge sys_clk) disable iff (!resetn)
        crest_restart |=> window_count == 8'h00)
        else $error("crest window counter not restarted");

    AST_CREST_IRQ: assert property (@(posedge sys_clk) disable iff (!resetn)
        (window_end && event_enable_reg[VOLTAGE_DONE_BIT]) |=> !event_irq_n)
        else $error("enabled crest window end left interrupt high");

    AST_DIP_FLAGS_WITH_STATUS: assert property (@(posedge sys_clk) disable iff (!resetn)
        (dip_phase_flags != 3'h0) |-> event_status_reg[DIP_BIT])
        else $error("dip phase flag set without dip status");

    COV_DIP_IRQ: cover property (@(posedge sys_clk) disable iff (!resetn)
        (|dip_event) ##1 !event_irq_n);
    COV_DIP_PHASE_SWAP: cover property (@(posedge sys_clk) disable iff (!resetn)
        dip_phase_flags == 3'b001 ##[1:1000] dip_phase_flags == 3'b010);
    COV_CREST_END: cover property (@(posedge sys_clk) disable iff (!resetn)
        window_end && crest_phase_select == 3'b011);

endmodule : dip_crest_monitor
`default_nettype wire

// ---- test/host_model.sv ----
`default_nettype none
module host_model
    import dip_crest_pkg::*;
(
    input  wire logic        sys_clk,
    output logic             reg_write,
    output logic             reg_read,
    output logic [7:0]       reg_addr,
    output logic [31:0]      reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_rvalid,
    input  wire logic        event_irq_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial
    begin
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_addr  = 8'hff;
        reg_wdata = 32'ha5a5_a5a5;
    end

    // One-cycle write strobe; data inverted afterwards so a stale word is never reused
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        reg_wdata <= ~data;
    endtask : wr

    // Threshold travels as a full word, top byte zero
    task automatic wr_threshold(input logic [23:0] level);
        wr(DIP_THRESHOLD_ADDR, {8'h00, level});
    endtask : wr_threshold

    // Read; a missing valid strobe returns unknowns so the caller's compare fails
    task automatic rd(input logic [7:0] addr, output logic [31:0] data);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= addr;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(posedge sys_clk);
        data = reg_rvalid ? reg_rdata : 32'hxxxx_xxxx;
    endtask : rd

    // Wait for the pin, read status, then the detail word, then clear
    task automatic service(input logic [7:0] detail_addr, input logic [31:0] clear_mask,
                           output logic [31:0] status, output logic [31:0] detail, output logic seen);
        int n;
        n = 0;
        while (event_irq_n !== 1'b0 && n < 2000)
        begin
            @(posedge sys_clk);
            n++;
        end
        seen = (event_irq_n === 1'b0);
        rd(EVENT_STATUS_ADDR, status);
        rd(detail_addr, detail);
        wr(EVENT_STATUS_ADDR, clear_mask);
    endtask : service

endmodule : host_model
`default_nettype wire

// ---- test/tb_voltage_dip_and_crest_monitor.sv ----
`default_nettype none
module tb_voltage_dip_and_crest_monitor
    import dip_crest_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             sys_clk;
    logic             resetn;
    logic             reg_write, reg_read, reg_rvalid, sample_valid, event_irq_n, seen;
    logic [7:0]       reg_addr;
    logic [31:0]      reg_wdata, reg_rdata, st, dt;
    logic [2:0][23:0] volt, curr;
    logic [2:0]       zero_cross;
    int               mismatches, comparisons;

    dip_crest_monitor dip_crest_monitor_i (.sys_clk(sys_clk), .resetn(resetn), .reg_write(reg_write),
        .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .sample_valid(sample_valid), .volt_sample(volt), .curr_sample(curr),
        .zero_cross(zero_cross), .event_irq_n(event_irq_n));
    host_model host_model_i (.sys_clk(sys_clk), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .event_irq_n(event_irq_n));

    // 100 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
        comparisons++;
        if (seen_v !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen_v);
        end
    endtask : check

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic chk_reg(input string name, input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        host_model_i.rd(addr, d);
        check(name, d, exp);
    endtask : chk_reg

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        host_model_i.wr(addr, data);
    endtask : wr

    // Half line cycles: four samples, then a crossing with no sample, then settling time
    task automatic tick(input int k, input logic [2:0] zc);
        repeat (k)
        begin
            repeat (4)
            begin
                @(posedge sys_clk);
                sample_valid <= 1'b1;
            end
            @(posedge sys_clk);
            sample_valid <= 1'b0;
            zero_cross   <= zc;
            @(posedge sys_clk);
            zero_cross   <= 3'h0;
            repeat (3) @(posedge sys_clk);
        end
    endtask : tick

    task automatic t_reset;
        chk_reg("enable", EVENT_ENABLE_ADDR, EVENT_ENABLE_RESET);
        chk_reg("dip cycles", DIP_CYCLES_ADDR, {24'h00_0000, DIP_CYCLES_RESET});
        chk_reg("unmapped", 8'h40, 32'h0000_0000);
        wr(VOLTAGE_CREST_ADDR, 32'h0000_1234);
        chk_reg("crest ro", VOLTAGE_CREST_ADDR, 32'h0000_0000);
        wr(DIP_THRESHOLD_ADDR, 32'hab00_0100);
        chk_reg("thr pad", DIP_THRESHOLD_ADDR, 32'h0000_0100);
    endtask : t_reset

    // Dip on A, then B replaces the flag, then one clear wipes all
    task automatic t_dip_phases;
        host_model_i.wr_threshold(24'h00_0100);
        wr(DIP_CYCLES_ADDR, 32'h0000_0002);
        wr(EVENT_ENABLE_ADDR, 32'h0001_0000);
        volt <= {24'h00_1000, 24'h00_1000, 24'hff_ff80};
        tick(3, 3'h7);
        chk_reg("flags a", PHASE_STATUS_ADDR, 32'h0000_1000);
        volt <= {24'h00_1000, 24'h00_0080, 24'h00_1000};
        tick(3, 3'h7);
        host_model_i.service(PHASE_STATUS_ADDR, 32'h0001_0000, st, dt, seen);
        check("dip irq", {31'h0, seen}, 32'h0000_0001);
        check("dip status", st, 32'h0001_0000);
        check("flags b", dt, 32'h0000_2000);
        chk_reg("flags clr", PHASE_STATUS_ADDR, 32'h0000_0000);
        check("irq clr", {31'h0, event_irq_n}, 32'h0000_0001);
    endtask : t_dip_phases

    // Count restarts on a cycle-count write and on a half above threshold
    task automatic t_dip_restart;
        volt <= {24'h00_1000, 24'h00_1000, 24'h00_0080};
        wr(DIP_CYCLES_ADDR, 32'h0000_0002);
        tick(2, 3'h1);
        wr(DIP_CYCLES_ADDR, 32'h0000_0002);
        tick(1, 3'h1);
        chk_reg("no dip", EVENT_STATUS_ADDR, 32'h0000_0000);
        tick(2, 3'h1);
        chk_reg("dip n", EVENT_STATUS_ADDR, 32'h0001_0000);
        wr(EVENT_STATUS_ADDR, 32'h0001_0000);
        wr(DIP_CYCLES_ADDR, 32'h0000_0002);
        tick(2, 3'h1);
        volt[0] <= 24'h00_0101;
        tick(1, 3'h1);
        volt[0] <= 24'h00_0100;
        tick(1, 3'h1);
        chk_reg("broken", EVENT_STATUS_ADDR, 32'h0000_0000);
        tick(1, 3'h1);
        chk_reg("equal", EVENT_STATUS_ADDR, 32'h0001_0000);
        wr(EVENT_STATUS_ADDR, 32'h0001_0000);
    endtask : t_dip_restart

    // Thresholds zero and one never fire; full scale fires on every phase
    task automatic t_dip_levels;
        volt <= '0;
        for (int i = 0; i < 2; i++)
        begin
            host_model_i.wr_threshold(24'(i));
            wr(DIP_CYCLES_ADDR, 32'h0000_0001);
            tick(3, 3'h7);
            chk_reg("thr off", EVENT_STATUS_ADDR, 32'h0000_0000);
        end
        host_model_i.wr_threshold(FULL_SCALE);
        volt <= {3{FULL_SCALE}};
        wr(DIP_CYCLES_ADDR, 32'h0000_0001);
        tick(2, 3'h7);
        host_model_i.service(PHASE_STATUS_ADDR, 32'h0001_0000, st, dt, seen);
        check("full scale", dt, 32'h0000_7000);
        host_model_i.wr_threshold(24'h00_0000);
    endtask : t_dip_levels

    // Two windows on phases A and B; C crossings must not count
    task automatic t_crest;
        wr(EVENT_ENABLE_ADDR, 32'h0180_0000);
        curr <= {24'h00_7000, 24'h00_0200, 24'h00_0300};
        volt <= {24'h00_7000, 24'hff_fc00, 24'h00_0050};
        wr(MEAS_MODE_ADDR, 32'h0000_000c);
        // Stray crossing before the count write; only a restart discards it
        tick(1, 3'h1);
        wr(CREST_CYCLES_ADDR, 32'h0000_0004);
        tick(1, 3'h3);
        tick(1, 3'h4);
        tick(1, 3'h1);
        chk_reg("early", CURRENT_CREST_ADDR, 32'h0000_0000);
        tick(1, 3'h1);
        host_model_i.service(CURRENT_CREST_ADDR, 32'h0180_0000, st, dt, seen);
        check("crest irq", {31'h0, seen}, 32'h0000_0001);
        check("crest status", st, 32'h0180_0000);
        check("i crest 1", dt, 32'h0100_0300);
        chk_reg("v crest 1", VOLTAGE_CREST_ADDR, 32'h0200_0400);
        wr(EVENT_ENABLE_ADDR, 32'h0000_0000);
        curr <= {24'h00_7000, 24'h00_0500, 24'h00_0010};
        tick(1, 3'h3);
        chk_reg("held", CURRENT_CREST_ADDR, 32'h0100_0300);
        tick(1, 3'h3);
        chk_reg("i crest 2", CURRENT_CREST_ADDR, 32'h0200_0500);
        chk_reg("status 2", EVENT_STATUS_ADDR, 32'h0180_0000);
        check("masked", {31'h0, event_irq_n}, 32'h0000_0001);
    endtask : t_crest

    // Main sequence
    initial
    begin
        resetn       = 1'b0;
        sample_valid = 1'b0;
        zero_cross   = 3'h0;
        volt         = '0;
        curr         = '0;
        mismatches   = 0;
        comparisons  = 0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset;
        t_dip_phases;
        t_dip_restart;
        t_dip_levels;
        t_crest;
        close_out;
    end

    // Watchdog, well beyond the few hundred cycles the run needs
    initial
    begin
        #200000;
        mismatches++;
        close_out;
    end

endmodule : tb_voltage_dip_and_crest_monitor
`default_nettype wire
